// ==== rtl/hdtf_pkg.sv ====
package hdtf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Host port geometry
    localparam int NUM_PORTS = 4;
    localparam int ADDR_W = 11;
    localparam int OFF_W = 9;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets inside one port window (port n adds n * 0x200)
    localparam logic [8:0] OFF_CTRL = 9'h110;
    localparam logic [8:0] OFF_WM_SEL = 9'h187;
    localparam logic [8:0] OFF_LATCHED = 9'h191;
    localparam logic [8:0] OFF_MASK = 9'h1A1;
    localparam logic [8:0] OFF_LIVE = 9'h1B1;
    localparam logic [8:0] OFF_FREE = 9'h1B3;
    localparam logic [8:0] OFF_FIFO = 9'h1B4;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int EV_W = 4;
    localparam int LIVE_EMPTY_BIT = 3;
    localparam int LIVE_FULL_BIT = 2;
    localparam int LIVE_BELOW_BIT = 1;
    localparam int LIVE_SPACE_BIT = 0;
    localparam int EV_UNDERRUN_BIT = 3;
    localparam int EV_MSG_DONE_BIT = 2;
    localparam int EV_WM_CROSS_BIT = 1;
    localparam int EV_SPACE_BIT = 0;
    localparam int CTRL_FILL_BIT = 3;
    localparam int CTRL_EOM_BIT = 2;
    localparam int WM_SEL_W = 2;

    ////////////////////////////////////////////////////////////////////////
    // FIFO sizing and watermark levels
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam logic [6:0] FIFO_DEPTH_CNT = 7'h40;
    localparam logic [6:0] WM_LEVEL_0 = 7'h04;
    localparam logic [6:0] WM_LEVEL_1 = 7'h10;
    localparam logic [6:0] WM_LEVEL_2 = 7'h20;
    localparam logic [6:0] WM_LEVEL_3 = 7'h30;

    ////////////////////////////////////////////////////////////////////////
    // Line bytes
    localparam logic [7:0] ABORT_BYTE = 8'hFE;
    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [3:0] LATCHED_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [1:0] WM_SEL_RST = 2'h0;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic BELOW_PREV_RST = 1'b1;
    localparam logic SPACE_PREV_RST = 1'b1;
    localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

// ==== rtl/hdtf_fifo.sv ====
`timescale 1ns/1ps
module hdtf_fifo
    import hdtf_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Fill side
    input wire logic push_i,
    input wire logic [8:0] push_data_i,
    // Drain side
    input wire logic pop_i,
    output logic [8:0] head_o,
    // Level
    output logic [6:0] count_o,
    output logic empty_o,
    output logic full_o
);

    // Byte plus end-of-message tag per entry
    logic [8:0] mem [0:FIFO_DEPTH-1];
    logic [5:0] wr_ptr, next_wr_ptr;
    logic [5:0] rd_ptr, next_rd_ptr;
    logic [6:0] count, next_count;
    logic do_push, do_pop;

    ////////////////////////////////////////////////////////////////////////
    // Push ignored when full, pop ignored when empty
    always_comb begin
        do_push = push_i && (count != FIFO_DEPTH_CNT);
        do_pop = pop_i && (count != 7'h00);
        next_wr_ptr = do_push ? wr_ptr + 6'h01 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 6'h01 : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + 7'h01;
        end else if (do_pop && !do_push) begin
            next_count = count - 7'h01;
        end
    end

    // Pointer and level registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            count <= 7'h00;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clock_i) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data_i;
        end
    end

    // Status straight from the level register
    assign head_o = mem[rd_ptr];
    assign count_o = count;
    assign empty_o = (count == 7'h00);
    assign full_o = (count == FIFO_DEPTH_CNT);

endmodule

// ==== rtl/hdtf_byte_src.sv ====
`timescale 1ns/1ps
module hdtf_byte_src
    import hdtf_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Request from the bit engine
    input wire logic pop_i,
    input wire logic empty_i,
    input wire logic underrun_i,
    input wire logic [8:0] head_i,
    input wire logic fill_sel_i,
    // Byte towards the bit engine
    output logic [7:0] tx_byte_o,
    output logic tx_eom_o
);

    logic [7:0] tx_byte, next_tx_byte;
    logic tx_eom, next_tx_eom;

    ////////////////////////////////////////////////////////////////////////
    // Byte choice on each request: data, one abort, or fill
    always_comb begin
        next_tx_byte = tx_byte;
        next_tx_eom = tx_eom;
        if (pop_i) begin
            next_tx_eom = 1'b0;
            if (!empty_i) begin
                next_tx_byte = head_i[7:0];
                next_tx_eom = head_i[8];
            end else if (underrun_i) begin
                next_tx_byte = ABORT_BYTE;
            end else begin
                next_tx_byte = fill_sel_i ? IDLE_BYTE : FLAG_BYTE;
            end
        end
    end

    // Output byte register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_byte <= FLAG_BYTE;
            tx_eom <= 1'b0;
        end else begin
            tx_byte <= next_tx_byte;
            tx_eom <= next_tx_eom;
        end
    end

    assign tx_byte_o = tx_byte;
    assign tx_eom_o = tx_eom;

endmodule

// ==== rtl/hdtf_top.sv ====
`timescale 1ns/1ps
module hdtf_top
    import hdtf_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Host parallel port
    input wire logic [10:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    // Interrupt, active low
    output logic int_n_o,
    // Bit engine side, one lane per port
    input wire logic [3:0] tx_pop_i,
    input wire logic [3:0] msg_sent_i,
    output logic [31:0] tx_byte_o,
    output logic [3:0] tx_eom_o,
    output logic [3:0] tx_abort_o
);

    ////////////////////////////////////////////////////////////////////////
    // Address split
    // Bits 10:9 pick one of four port windows, each 0x200 wide,
    // so one offset decode serves every copy below
    logic [1:0] host_port;
    logic [8:0] host_off;
    // Per-port readback and interrupt request
    logic [7:0] port_rdata [0:NUM_PORTS-1];
    logic [3:0] port_irq;
    // Read strobe history
    logic host_rd_q, next_host_rd_q;
    // Read data holding register
    // Holds until the next read start
    logic [7:0] rdata, next_rdata;
    // Interrupt output register
    logic int_n, next_int_n;

    assign host_port = host_addr_i[10:9];
    assign host_off = host_addr_i[8:0];

    ////////////////////////////////////////////////////////////////////////
    // per-port copies
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            // Decoded write strobes
            logic sel;
            logic wr_ctrl, wr_wm, wr_lat, wr_mask, wr_fifo;
            // Software state
            logic [3:0] latched, next_latched;
            logic [3:0] mask, next_mask;
            logic [1:0] wm_sel, next_wm_sel;
            logic [1:0] ctrl, next_ctrl;
            // Edge history and message tracking
            // History starts at the idle level of an empty FIFO, so
            // leaving reset never looks like a rising edge
            logic below_prev, next_below_prev;
            logic space_prev, next_space_prev;
            logic in_msg, next_in_msg;
            logic abort_q, next_abort_q;
            // FIFO view
            logic [8:0] head;
            logic [6:0] count;
            logic empty, full;
            // Derived live state
            logic [6:0] wm_level;
            logic below, space;
            logic [6:0] free_cnt;
            logic [3:0] live;
            logic [3:0] ev_set;
            logic underrun, pop_data;

            ////////////////////////////////////////////////////////////////
            // Strobes for this port window
            // Offsets never overlap, so at most one strobe is high
            always_comb begin
                sel = (host_port == 2'(p));
                wr_ctrl = host_wr_i && sel && (host_off == OFF_CTRL);
                wr_wm = host_wr_i && sel && (host_off == OFF_WM_SEL);
                wr_lat = host_wr_i && sel && (host_off == OFF_LATCHED);
                wr_mask = host_wr_i && sel && (host_off == OFF_MASK);
                wr_fifo = host_wr_i && sel && (host_off == OFF_FIFO);
            end

            ////////////////////////////////////////////////////////////////
            // Transmit byte storage
            // Entry bit 8 carries the end marker seen at write time
            // write enqueues byte
            hdtf_fifo u_fifo (
                .clock_i(clock_i),
                .resetn_i(resetn_i),
                .push_i(wr_fifo),
                .push_data_i({ctrl[CTRL_EOM_BIT-2], host_wdata_i}),
                .pop_i(tx_pop_i[p]),
                .head_o(head),
                .count_o(count),
                .empty_o(empty),
                .full_o(full)
            );

            ////////////////////////////////////////////////////////////////
            // Live conditions, pure functions of the level
            // No history here: these bits follow the level each cycle
            always_comb begin
                case (wm_sel)
                    2'h0: wm_level = WM_LEVEL_0;
                    2'h1: wm_level = WM_LEVEL_1;
                    2'h2: wm_level = WM_LEVEL_2;
                    default: wm_level = WM_LEVEL_3;
                endcase
                below = (count < wm_level);
                space = !full;
                // free space
                // Reads 64 when empty and 0 when full
                free_cnt = FIFO_DEPTH_CNT - count;
                live = 4'h0;
                live[LIVE_EMPTY_BIT] = empty;
                live[LIVE_FULL_BIT] = full;
                live[LIVE_BELOW_BIT] = below;
                live[LIVE_SPACE_BIT] = space;
            end

            ////////////////////////////////////////////////////////////////
            // Event sources
            // Each source is a one-cycle pulse, the latch keeps it
            always_comb begin
                pop_data = tx_pop_i[p] && !empty;
                // empty mid-message
                // An idle pop outside a message only gives fill
                underrun = tx_pop_i[p] && empty && in_msg;
                ev_set = 4'h0;
                ev_set[EV_UNDERRUN_BIT] = underrun;
                ev_set[EV_MSG_DONE_BIT] = msg_sent_i[p];
                ev_set[EV_WM_CROSS_BIT] = below && !below_prev;
                ev_set[EV_SPACE_BIT] = space && !space_prev;
            end

            ////////////////////////////////////////////////////////////////
            // Next values of this port's registers
            always_comb begin
                // hold, clear ones, set wins
                // An event landing on the clear cycle survives, so the
                // host never loses an event it has not yet seen
                next_latched = (latched & ~(wr_lat ? host_wdata_i[3:0] : 4'h0)) | ev_set;
                // Mask keeps low nibble only
                // Upper four bits are not stored and read back zero
                next_mask = wr_mask ? host_wdata_i[3:0] : mask;
                next_wm_sel = wr_wm ? host_wdata_i[1:0] : wm_sel;
                // Only fill select and end marker are kept
                next_ctrl = ctrl;
                if (wr_ctrl) begin
                    next_ctrl = host_wdata_i[CTRL_FILL_BIT:CTRL_EOM_BIT];
                end else if (wr_fifo && !full) begin
                    next_ctrl[CTRL_EOM_BIT-2] = 1'b0;
                end
                next_below_prev = below;
                next_space_prev = space;
                // Inside a message until its tagged byte leaves
                // An untagged byte opens a message, the tagged one closes it
                // After an underrun the lane stays idle until new data
                next_in_msg = in_msg;
                if (pop_data) begin
                    next_in_msg = !head[8];
                end else if (underrun) begin
                    next_in_msg = 1'b0;
                end
                // Abort flag pulses once beside the abort byte
                next_abort_q = underrun;
            end

            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    latched <= LATCHED_RST;
                    mask <= MASK_RST;
                    wm_sel <= WM_SEL_RST;
                    ctrl <= CTRL_RST;
                    below_prev <= BELOW_PREV_RST;
                    space_prev <= SPACE_PREV_RST;
                    in_msg <= 1'b0;
                    abort_q <= 1'b0;
                end else begin
                    latched <= next_latched;
                    mask <= next_mask;
                    wm_sel <= next_wm_sel;
                    ctrl <= next_ctrl;
                    below_prev <= next_below_prev;
                    space_prev <= next_space_prev;
                    in_msg <= next_in_msg;
                    abort_q <= next_abort_q;
                end
            end

            ////////////////////////////////////////////////////////////////
            // Byte source towards the bit engine
            hdtf_byte_src u_src (
                .clock_i(clock_i),
                .resetn_i(resetn_i),
                .pop_i(tx_pop_i[p]),
                .empty_i(empty),
                .underrun_i(underrun),
                .head_i(head),
                .fill_sel_i(ctrl[CTRL_FILL_BIT-2]),
                .tx_byte_o(tx_byte_o[8*p+7:8*p]),
                .tx_eom_o(tx_eom_o[p])
            );
            assign tx_abort_o[p] = abort_q;

            ////////////////////////////////////////////////////////////////
            // mask gates each event
            // One request per port, any of them pulls the pin low
            assign port_irq[p] = |(latched & mask);

            ////////////////////////////////////////////////////////////////
            // Readback mux, unmapped offsets read zero
            // Write-only data port reads zero like any unused offset
            always_comb begin
                case (host_off)
                    OFF_CTRL: port_rdata[p] = {4'h0, ctrl, 2'h0};
                    OFF_WM_SEL: port_rdata[p] = {6'h00, wm_sel};
                    OFF_LATCHED: port_rdata[p] = {4'h0, latched};
                    OFF_MASK: port_rdata[p] = {4'h0, mask};
                    // live bits from present level only
                    OFF_LIVE: port_rdata[p] = {4'h0, live};
                    OFF_FREE: port_rdata[p] = {1'b0, free_cnt};
                    default: port_rdata[p] = 8'h00;
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Host read capture and interrupt summary
    always_comb begin
        next_host_rd_q = host_rd_i;
        next_rdata = rdata;
        // sample once at start of read
        // The port mux moves with the FIFO level during a long read,
        // so only the first cycle of a read is captured
        if (host_rd_i && !host_rd_q) begin
            next_rdata = port_rdata[host_port];
        end
        // low while any unmasked event pends
        // Registered so the pin never glitches on decode changes
        next_int_n = !(|port_irq);
    end

    // Host side registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rd_q <= 1'b0;
            rdata <= RDATA_RST;
            int_n <= 1'b1;
        end else begin
            host_rd_q <= next_host_rd_q;
            rdata <= next_rdata;
            int_n <= next_int_n;
        end
    end

    assign host_rdata_o = rdata;
    assign int_n_o = int_n;

endmodule

// ==== verification/hdtf_monitor.sv ====
`timescale 1ns/1ps
module hdtf_monitor
    import hdtf_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Host port
    input wire logic [10:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic int_n_o,
    // Engine lanes
    input wire logic [3:0] tx_pop_i,
    input wire logic [3:0] msg_sent_i,
    input wire logic [31:0] tx_byte_o,
    input wire logic [3:0] tx_eom_o,
    input wire logic [3:0] tx_abort_o
);
    logic rd_q; // Read level one cycle old
    logic rd_start; // First cycle of a read
    logic [8:0] off; // Offset inside a port
    assign rd_start = host_rd_i && !rd_q;
    assign off = host_addr_i[8:0];
    // Read level history
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= host_rd_i;
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////
    abort_one_shot_a: assert property (tx_abort_o[0] |=> !tx_abort_o[0])
        else $error("abort pulse longer than one cycle");
    abort_byte_a: assert property (tx_abort_o[0] |-> tx_byte_o[7:0] == ABORT_BYTE)
        else $error("abort without abort byte");
    abort_cause_a: assert property (tx_abort_o[0] |-> $past(tx_pop_i[0]))
        else $error("abort without a pop");
    byte_hold_a: assert property (!$past(tx_pop_i[0]) |-> $stable(tx_byte_o[7:0]) && $stable(tx_eom_o[0]))
        else $error("lane byte moved without a pop");
    read_stable_a: assert property (host_rd_i && $past(host_rd_i) && $past(host_rd_i, 2) |-> $stable(host_rdata_o))
        else $error("read data moved during a read");
    live_flags_a: assert property (rd_start && off == OFF_LIVE |=>
        host_rdata_o[7:4] == 4'h0 && host_rdata_o[0] == !host_rdata_o[2])
        else $error("live flags inconsistent");
    empty_below_a: assert property (rd_start && off == OFF_LIVE |=>
        !host_rdata_o[3] || host_rdata_o[2:0] == 3'h3)
        else $error("empty without below and space");
    free_range_a: assert property (rd_start && off == OFF_FREE |=> host_rdata_o <= {1'b0, FIFO_DEPTH_CNT})
        else $error("free count out of range");
    latched_upper_a: assert property (rd_start && off == OFF_LATCHED |=> host_rdata_o[7:4] == 4'h0)
        else $error("latched upper bits set");
endmodule
bind hdtf_top hdtf_monitor mon_u (.clock_i(clock_i), .resetn_i(resetn_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .int_n_o(int_n_o), .tx_pop_i(tx_pop_i), .msg_sent_i(msg_sent_i), .tx_byte_o(tx_byte_o),
    .tx_eom_o(tx_eom_o), .tx_abort_o(tx_abort_o));

// ==== verification/hdtf_engine_model.sv ====
`timescale 1ns/1ps
module hdtf_engine_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Commands from the bench
    input wire logic [3:0] pop_cmd_i,
    input wire logic [3:0] sent_cmd_i,
    // Lanes towards the block
    output logic [3:0] tx_pop_o,
    output logic [3:0] msg_sent_o,
    input wire logic [31:0] tx_byte_i,
    input wire logic [3:0] tx_eom_i,
    input wire logic [3:0] tx_abort_i,
    // Last answer per lane
    output logic [31:0] cap_byte_o,
    output logic [3:0] cap_eom_o,
    output logic [3:0] cap_abort_o
);
    logic [3:0] pop_d; // Pops taken last cycle
    // Pulses out, answers captured one cycle after each pop
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_pop_o <= 4'h0;
            msg_sent_o <= 4'h0;
            pop_d <= 4'h0;
            cap_byte_o <= 32'h0;
            cap_eom_o <= 4'h0;
            cap_abort_o <= 4'h0;
        end else begin
            tx_pop_o <= pop_cmd_i;
            msg_sent_o <= sent_cmd_i;
            pop_d <= tx_pop_o;
            for (int p = 0; p < 4; p++) begin
                if (pop_d[p]) begin
                    cap_byte_o[8*p +: 8] <= tx_byte_i[8*p +: 8];
                    cap_eom_o[p] <= tx_eom_i[p];
                    cap_abort_o[p] <= tx_abort_i[p];
                end
            end
        end
    end
endmodule

// ==== verification/hdtf_top_tb_top.sv ====
`timescale 1ns/1ps
module hdtf_top_tb_top;
    import hdtf_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [10:0] addr = 11'h000; // Host address
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic int_n;
    logic [3:0] pop_cmd = 4'h0; // Pop requests to the model
    logic [3:0] sent_cmd = 4'h0;
    logic [3:0] pop, sent, eom, abrt, c_eom, c_abort;
    logic [31:0] tx_b, c_byte;
    int err_count = 0;
    int checks = 0;
    hdtf_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .host_addr_i(addr), .host_wr_i(wr),
        .host_rd_i(rd), .host_wdata_i(wdata), .host_rdata_o(rdata), .int_n_o(int_n), .tx_pop_i(pop),
        .msg_sent_i(sent), .tx_byte_o(tx_b), .tx_eom_o(eom), .tx_abort_o(abrt));
    hdtf_engine_model partner_u (.clock_i(clock_i), .resetn_i(resetn_i), .pop_cmd_i(pop_cmd),
        .sent_cmd_i(sent_cmd), .tx_pop_o(pop), .msg_sent_o(sent), .tx_byte_i(tx_b), .tx_eom_i(eom),
        .tx_abort_i(abrt), .cap_byte_o(c_byte), .cap_eom_o(c_eom), .cap_abort_o(c_abort));
    // 250 MHz clock
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input int p, input logic [8:0] off, input logic [7:0] d);
        @(posedge clock_i);
        addr <= {p[1:0], off};
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rchk(input int p, input logic [8:0] off, input logic [7:0] exp);
        logic [7:0] d;
        @(posedge clock_i);
        addr <= {p[1:0], off};
        rd <= 1'b1;
        @(posedge clock_i);
        #1 d = rdata;
        // Hold the read two more edges, data must not move
        repeat (2) @(posedge clock_i);
        rd <= 1'b0;
        cmp(d, exp);
        cmp(rdata, d);
    endtask
    // Pop one byte on lane p, flags are abort and end marker
    task automatic popc(input int p, input logic [7:0] eb, input logic [1:0] ef);
        @(posedge clock_i);
        pop_cmd <= 4'h1 << p;
        @(posedge clock_i);
        pop_cmd <= 4'h0;
        repeat (2) @(posedge clock_i);
        #1 cmp(c_byte[8*p +: 8], eb);
        cmp({6'h00, c_abort[p], c_eom[p]}, {6'h00, ef});
    endtask
    task automatic int_chk(input logic exp);
        repeat (3) @(posedge clock_i);
        #1 cmp({7'h00, int_n}, {7'h00, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int p = 0; p < 4; p++) begin
            rchk(p, OFF_LATCHED, 8'h00);
            rchk(p, OFF_MASK, 8'h00);
            rchk(p, OFF_LIVE, 8'h0B);
            rchk(p, OFF_FREE, 8'h40);
        end
        rchk(0, 9'h000, 8'h00);
        int_chk(1'b1);
    endtask
    task automatic t_fill();
        for (int i = 0; i < 65; i++) begin
            wreg(0, OFF_FIFO, 8'h80 | 8'(i));
        end
        rchk(0, OFF_FREE, 8'h00);
        rchk(0, OFF_LIVE, 8'h04);
        rchk(0, OFF_LATCHED, 8'h00);
        popc(0, 8'h80, 2'b00);
        rchk(0, OFF_FREE, 8'h01);
        rchk(0, OFF_LIVE, 8'h01);
        rchk(0, OFF_LATCHED, 8'h01);
        wreg(0, OFF_LATCHED, 8'h01);
        rchk(0, OFF_LATCHED, 8'h00);
        for (int i = 1; i < 64; i++) begin
            popc(0, 8'h80 | 8'(i), 2'b00);
            if (i == 60) begin
                rchk(0, OFF_LIVE, 8'h03);
                rchk(0, OFF_LATCHED, 8'h02);
            end
        end
        rchk(0, OFF_LIVE, 8'h0B);
        popc(0, ABORT_BYTE, 2'b10);
        popc(0, FLAG_BYTE, 2'b00);
        wreg(0, OFF_CTRL, 8'h08);
        popc(0, IDLE_BYTE, 2'b00);
        wreg(0, OFF_CTRL, 8'h00);
        rchk(0, OFF_LATCHED, 8'h0A);
    endtask
    task automatic t_irq();
        int_chk(1'b1);
        wreg(0, OFF_MASK, 8'h02);
        int_chk(1'b0);
        wreg(0, OFF_LATCHED, 8'h08);
        rchk(0, OFF_LATCHED, 8'h02);
        int_chk(1'b0);
        wreg(0, OFF_LIVE, 8'hFF);
        rchk(0, OFF_LIVE, 8'h0B);
        wreg(0, OFF_LATCHED, 8'h02);
        int_chk(1'b1);
        wreg(0, OFF_MASK, 8'h0F);
        rchk(0, OFF_MASK, 8'h0F);
    endtask
    task automatic t_wm();
        int lv [4] = '{4, 16, 32, 48};
        for (int c = 0; c < 4; c++) begin
            wreg(1, OFF_WM_SEL, 8'(c));
            for (int i = 0; i < lv[c] - 1; i++) begin
                wreg(1, OFF_FIFO, 8'(i));
            end
            rchk(1, OFF_LIVE, 8'h03);
            wreg(1, OFF_FIFO, 8'(lv[c] - 1));
            rchk(1, OFF_LIVE, 8'h01);
            // Level drops during this read, captured count must hold
            fork
                rchk(1, OFF_FREE, 8'(64 - lv[c]));
                popc(1, 8'h00, 2'b00);
            join
            for (int i = 1; i < lv[c]; i++) begin
                popc(1, 8'(i), 2'b00);
            end
        end
    endtask
    task automatic t_eom();
        wreg(2, OFF_MASK, 8'h04);
        wreg(2, OFF_FIFO, 8'h5A);
        rchk(2, OFF_FREE, 8'h3F);
        rchk(3, OFF_FREE, 8'h40);
        wreg(2, OFF_CTRL, 8'h04);
        wreg(2, OFF_FIFO, 8'hA5);
        popc(2, 8'h5A, 2'b00);
        popc(2, 8'hA5, 2'b01);
        popc(2, FLAG_BYTE, 2'b00);
        rchk(2, OFF_LATCHED, 8'h00);
        @(posedge clock_i);
        sent_cmd <= 4'h4;
        @(posedge clock_i);
        sent_cmd <= 4'h0;
        int_chk(1'b0);
        rchk(2, OFF_LATCHED, 8'h04);
        wreg(2, OFF_LATCHED, 8'h04);
        int_chk(1'b1);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_fill();
        t_irq();
        t_wm();
        t_eom();
        stop_test();
    end
    // Hang guard
    initial begin
        #300000;
        err_count++;
        stop_test();
    end
endmodule
